// file: pirq_consts.svh
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH

`define PIRQ_ADDR_W 8
`define PIRQ_OFF_EN5 8'h00
`define PIRQ_OFF_EN6 8'h04
`define PIRQ_OFF_PRIO1 8'h08
`define PIRQ_OFF_PRIO2 8'h0c
`define PIRQ_OFF_PRIO3 8'h10
`define PIRQ_OFF_PRIO4 8'h14
`define PIRQ_OFF_PRIO5 8'h18
`define PIRQ_OFF_CTRL 8'h1c
`define PIRQ_OFF_STAT 8'h20
`define PIRQ_OFF_MASK 8'h24
`define PIRQ_OFF_REQV 8'h28

`define PIRQ_CLKTUNE_RANGE_IRQ_EN_BIT 6
`define PIRQ_CLKTUNE_LOCK_IRQ_EN_BIT 5
`define PIRQ_TIMER8_MATCH_IRQ_EN_BIT 4
`define PIRQ_TIMER6_MATCH_IRQ_EN_BIT 2
`define PIRQ_TIMER5_OVF_IRQ_EN_BIT 1
`define PIRQ_TIMER4_MATCH_IRQ_EN_BIT 0
`define PIRQ_UART4_RX_IRQ_EN_BIT 7
`define PIRQ_UART4_TX_IRQ_EN_BIT 6
`define PIRQ_UART3_RX_IRQ_EN_BIT 5
`define PIRQ_UART3_TX_IRQ_EN_BIT 4
`define PIRQ_COMPARATOR3_IRQ_EN_BIT 2
`define PIRQ_COMPARATOR2_IRQ_EN_BIT 1
`define PIRQ_COMPARATOR1_IRQ_EN_BIT 0

`define PIRQ_EN5_IMPL ((8'h01 << `PIRQ_CLKTUNE_RANGE_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_CLKTUNE_LOCK_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_TIMER8_MATCH_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_TIMER6_MATCH_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_TIMER5_OVF_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_TIMER4_MATCH_IRQ_EN_BIT))
`define PIRQ_EN6_IMPL ((8'h01 << `PIRQ_UART4_RX_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_UART4_TX_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_UART3_RX_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_UART3_TX_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_COMPARATOR3_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_COMPARATOR2_IRQ_EN_BIT) | \
  (8'h01 << `PIRQ_COMPARATOR1_IRQ_EN_BIT))
`define PIRQ_PRIO_IMPL 8'hff
`define PIRQ_PRIO5_IMPL `PIRQ_EN5_IMPL

`define PIRQ_EN_RST 8'h00
`define PIRQ_PRIO_RST 8'hff

`define PIRQ_CTRL_PRIO_EN_BIT 7
`define PIRQ_CTRL_PERIPH_EN_BIT 6
`define PIRQ_STAT_HIGH_BIT 0
`define PIRQ_STAT_LOW_BIT 1

`define PIRQ_RESP_OKAY 2'h0
`define PIRQ_RESP_SLVERR 2'h2

`endif

// file: pirq_pkg.sv
package pirq_pkg;

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] en5;
    logic [7:0] en6;
    logic [4:0][7:0] prio;
    logic priority_levels_enable;
    logic peripheral_global_irq_en;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic req_hi;
    logic req_lo;
    logic irq;
  } pirq_state_t;

endpackage

// file: pirq_ctrl.sv
`timescale 1ns/1ps
`include "pirq_consts.svh"

module pirq_ctrl (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic [7:0] FLAG_G1_IN,
  input wire logic [7:0] FLAG_G2_IN,
  input wire logic [7:0] FLAG_G3_IN,
  input wire logic [7:0] FLAG_G4_IN,
  input wire logic [7:0] FLAG_G5_IN,
  input wire logic [7:0] FLAG_G6_IN,
  input wire logic [7:0] ENABLE_G1_IN,
  input wire logic [7:0] ENABLE_G2_IN,
  input wire logic [7:0] ENABLE_G3_IN,
  input wire logic [7:0] ENABLE_G4_IN,
  input wire logic [7:0] PRIO_G6_IN,
  output logic HIGH_REQ_OUT,
  output logic LOW_REQ_OUT,
  output logic IRQ_OUT
);

  pirq_pkg::pirq_state_t s;
  pirq_pkg::pirq_state_t next_s;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [47:0] req_all;
  logic [47:0] prio_all;
  logic hi_any;
  logic lo_any;
  logic [8:0] rd_result;

  function automatic logic same_word(input logic [7:0] a,
                                     input logic [7:0] b);
    same_word = (a[7:2] == b[7:2]);
  endfunction

  // Masked byte write; unimplemented bits stay zero.
  function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                         input logic [7:0] data,
                                         input logic strb,
                                         input logic [7:0] impl);
    wr_byte = strb ? (data & impl) : old;
  endfunction

  // Returns the error flag above the read byte.
  function automatic logic [8:0] rd_decode(
      input pirq_pkg::pirq_state_t st,
      input logic [7:0] addr);
    logic [8:0] r;
    r = {1'b0, 8'h00};
    if (same_word(addr, `PIRQ_OFF_EN5))
      r = {1'b0, st.en5};
    else if (same_word(addr, `PIRQ_OFF_EN6))
      r = {1'b0, st.en6};
    else if (same_word(addr, `PIRQ_OFF_PRIO1))
      r = {1'b0, st.prio[0]};
    else if (same_word(addr, `PIRQ_OFF_PRIO2))
      r = {1'b0, st.prio[1]};
    else if (same_word(addr, `PIRQ_OFF_PRIO3))
      r = {1'b0, st.prio[2]};
    else if (same_word(addr, `PIRQ_OFF_PRIO4))
      r = {1'b0, st.prio[3]};
    else if (same_word(addr, `PIRQ_OFF_PRIO5))
      r = {1'b0, st.prio[4]};
    else if (same_word(addr, `PIRQ_OFF_CTRL))
      r = {1'b0, st.priority_levels_enable,
           st.peripheral_global_irq_en, 6'h00};
    else if (same_word(addr, `PIRQ_OFF_STAT))
      r = {1'b0, 6'h00, st.irq_status};
    else if (same_word(addr, `PIRQ_OFF_MASK))
      r = {1'b0, 6'h00, st.irq_mask};
    else if (same_word(addr, `PIRQ_OFF_REQV))
      r = {1'b0, 6'h00, st.req_lo, st.req_hi};
    else
      r = {1'b1, 8'h00};
    rd_decode = r;
  endfunction

  function automatic pirq_pkg::pirq_state_t reset_state();
    pirq_pkg::pirq_state_t r;
    r = '0;
    r.en5 = `PIRQ_EN_RST;
    r.en6 = `PIRQ_EN_RST;
    r.prio[0] = `PIRQ_PRIO_RST;
    r.prio[1] = `PIRQ_PRIO_RST;
    r.prio[2] = `PIRQ_PRIO_RST;
    r.prio[3] = `PIRQ_PRIO_RST;
    r.prio[4] = `PIRQ_PRIO_RST & `PIRQ_PRIO5_IMPL;
    reset_state = r;
  endfunction

  assign AWREADY_OUT = CE_IN & ~s.aw_held & ~s.bvalid;
  assign WREADY_OUT = CE_IN & ~s.w_held & ~s.bvalid;
  assign ARREADY_OUT = CE_IN & ~s.rvalid;
  assign aw_take = AWVALID_IN & AWREADY_OUT;
  assign w_take = WVALID_IN & WREADY_OUT;
  assign ar_take = ARVALID_IN & ARREADY_OUT;

  assign BVALID_OUT = s.bvalid;
  assign BRESP_OUT = s.bresp;
  assign RVALID_OUT = s.rvalid;
  assign RRESP_OUT = s.rresp;
  assign RDATA_OUT = {24'h000000, s.rdata};
  assign HIGH_REQ_OUT = s.req_hi;
  assign LOW_REQ_OUT = s.req_lo;
  assign IRQ_OUT = s.irq;

  // A source asks when its flag and its enable are both set.
  assign req_all = {FLAG_G6_IN & s.en6, FLAG_G5_IN & s.en5,
                    FLAG_G4_IN & ENABLE_G4_IN, FLAG_G3_IN & ENABLE_G3_IN,
                    FLAG_G2_IN & ENABLE_G2_IN,
                    FLAG_G1_IN & ENABLE_G1_IN};
  // Each group's priority byte lines up bit for bit with its flags.
  assign prio_all = {PRIO_G6_IN, s.prio};

  // Two-level routing by priority bit, or one level behind the
  // peripheral global enable.
  always_comb
  begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    if (s.priority_levels_enable)
    begin
      hi_any = |(req_all & prio_all);
      lo_any = |(req_all & ~prio_all);
    end
    else
    begin
      hi_any = s.peripheral_global_irq_en & (|req_all);
    end
  end

  assign rd_result = rd_decode(s, ARADDR_IN);

  always_comb
  begin
    next_s = s;
    if (s.bvalid && BREADY_IN)
      next_s.bvalid = 1'b0;
    if (aw_take)
    begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = AWADDR_IN;
    end
    if (w_take)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata = WDATA_IN[7:0];
      next_s.wstrb0 = WSTRB_IN[0];
    end
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `PIRQ_RESP_OKAY;
      if (same_word(s.awaddr, `PIRQ_OFF_EN5))
        next_s.en5 = wr_byte(s.en5, s.wdata, s.wstrb0,
                             `PIRQ_EN5_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_EN6))
        next_s.en6 = wr_byte(s.en6, s.wdata, s.wstrb0,
                             `PIRQ_EN6_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_PRIO1))
        next_s.prio[0] = wr_byte(s.prio[0], s.wdata, s.wstrb0,
                                 `PIRQ_PRIO_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_PRIO2))
        next_s.prio[1] = wr_byte(s.prio[1], s.wdata, s.wstrb0,
                                 `PIRQ_PRIO_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_PRIO3))
        next_s.prio[2] = wr_byte(s.prio[2], s.wdata, s.wstrb0,
                                 `PIRQ_PRIO_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_PRIO4))
        next_s.prio[3] = wr_byte(s.prio[3], s.wdata, s.wstrb0,
                                 `PIRQ_PRIO_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_PRIO5))
        next_s.prio[4] = wr_byte(s.prio[4], s.wdata, s.wstrb0,
                                 `PIRQ_PRIO5_IMPL);
      else if (same_word(s.awaddr, `PIRQ_OFF_CTRL))
      begin
        if (s.wstrb0)
        begin
          next_s.priority_levels_enable =
            s.wdata[`PIRQ_CTRL_PRIO_EN_BIT];
          next_s.peripheral_global_irq_en =
            s.wdata[`PIRQ_CTRL_PERIPH_EN_BIT];
        end
      end
      else if (same_word(s.awaddr, `PIRQ_OFF_STAT))
      begin
        if (s.wstrb0)
          next_s.irq_status = s.irq_status & ~s.wdata[1:0];
      end
      else if (same_word(s.awaddr, `PIRQ_OFF_MASK))
      begin
        if (s.wstrb0)
          next_s.irq_mask = s.wdata[1:0];
      end
      else if (!same_word(s.awaddr, `PIRQ_OFF_REQV))
        next_s.bresp = `PIRQ_RESP_SLVERR;
    end
    if (s.rvalid && RREADY_IN)
      next_s.rvalid = 1'b0;
    if (ar_take)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_result[7:0];
      next_s.rresp = rd_result[8] ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
    end
    next_s.req_hi = hi_any;
    next_s.req_lo = lo_any;
    // New requests set status after any clear, so a set wins.
    if (hi_any && !s.req_hi)
      next_s.irq_status[`PIRQ_STAT_HIGH_BIT] = 1'b1;
    if (lo_any && !s.req_lo)
      next_s.irq_status[`PIRQ_STAT_LOW_BIT] = 1'b1;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      s <= reset_state();
    else if (CE_IN)
      s <= next_s;
  end

  chk_en5_reserved: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (s.en5[7] == 1'b0) && (s.en5[3] == 1'b0) &&
    (s.prio[4][7] == 1'b0) && (s.prio[4][3] == 1'b0))
    else $error("reserved group five bit set");

  chk_en6_reserved: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    s.en6[3] == 1'b0)
    else $error("reserved group six bit set");

  chk_enable_reset: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    $rose(RST_B_IN) |-> (s.en5 == 8'h00) && (s.en6 == 8'h00))
    else $error("enables not clear after reset");

  chk_prio_reset: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    $rose(RST_B_IN) |-> (s.prio[0] == 8'hff) && (s.prio[3] == 8'hff) &&
      (s.prio[4] == 8'h77) && !s.priority_levels_enable)
    else $error("priorities not preset after reset");

  chk_single_gate: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && !s.priority_levels_enable && !s.peripheral_global_irq_en
    |=> !HIGH_REQ_OUT)
    else $error("single level request without global enable");

  chk_single_no_low: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && !s.priority_levels_enable |=> !LOW_REQ_OUT)
    else $error("low level used in single level mode");

  chk_low_route: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.priority_levels_enable &&
    ((req_all & ~prio_all) != 48'h0) |=> LOW_REQ_OUT)
    else $error("low priority source not routed low");

  chk_high_route: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.priority_levels_enable &&
    ((req_all & prio_all) == 48'h0) |=> !HIGH_REQ_OUT)
    else $error("high request without high priority source");

  chk_idle_no_req: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && (req_all == 48'h0) |=> !HIGH_REQ_OUT && !LOW_REQ_OUT)
    else $error("request without flag and enable");

  chk_masked_en5: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.priority_levels_enable && (s.en5 == 8'h00) &&
    (FLAG_G5_IN != 8'h00) && ({req_all[47:40], req_all[31:0]} == 40'h0)
    |=> !HIGH_REQ_OUT && !LOW_REQ_OUT)
    else $error("disabled group five source requested");

  chk_write_resp: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.aw_held && s.w_held && !s.bvalid |=> BVALID_OUT)
    else $error("write response missing");

  chk_en5_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.aw_held && s.w_held && !s.bvalid && s.wstrb0 &&
    same_word(s.awaddr, `PIRQ_OFF_EN5)
    |=> s.en5 == ($past(s.wdata) & 8'h77))
    else $error("group five enable write lost");

  chk_en6_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.aw_held && s.w_held && !s.bvalid && s.wstrb0 &&
    same_word(s.awaddr, `PIRQ_OFF_EN6)
    |=> s.en6 == ($past(s.wdata) & 8'hf7))
    else $error("group six enable write lost");

  chk_prio1_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.aw_held && s.w_held && !s.bvalid && s.wstrb0 &&
    same_word(s.awaddr, `PIRQ_OFF_PRIO1)
    |=> s.prio[0] == $past(s.wdata))
    else $error("priority one write lost");

  chk_prio5_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.aw_held && s.w_held && !s.bvalid && s.wstrb0 &&
    same_word(s.awaddr, `PIRQ_OFF_PRIO5)
    |=> s.prio[4] == ($past(s.wdata) & 8'h77))
    else $error("priority five write lost");

  chk_high_route_set: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.priority_levels_enable &&
    ((req_all & prio_all) != 48'h0) |=> HIGH_REQ_OUT)
    else $error("high priority source not routed high");

  chk_single_route: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && !s.priority_levels_enable && s.peripheral_global_irq_en &&
    (req_all != 48'h0) |=> HIGH_REQ_OUT)
    else $error("single level request not passed");

  chk_status_high: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && hi_any && !s.req_hi
    |=> s.irq_status[`PIRQ_STAT_HIGH_BIT])
    else $error("high request edge not latched");

  chk_status_low: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && lo_any && !s.req_lo
    |=> s.irq_status[`PIRQ_STAT_LOW_BIT])
    else $error("low request edge not latched");

  chk_unmapped_err: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    CE_IN && s.aw_held && s.w_held && !s.bvalid &&
    (s.awaddr > (`PIRQ_OFF_REQV | 8'h03))
    |=> BRESP_OUT == `PIRQ_RESP_SLVERR)
    else $error("unmapped write not refused");

  // While the clock enable is low no state may move.
  chk_ce_freeze: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    !CE_IN |=> $stable(s))
    else $error("state moved with clock enable low");

endmodule // pirq_ctrl

// file: pirq_src_model.sv
`timescale 1ns/1ps

module pirq_src_model (
  input wire logic clk_in,
  input wire logic [47:0] event_in,
  output logic [7:0] flag_g1_out,
  output logic [7:0] flag_g2_out,
  output logic [7:0] flag_g3_out,
  output logic [7:0] flag_g4_out,
  output logic [7:0] flag_g5_out,
  output logic [7:0] flag_g6_out
);
  logic [47:0] flags = 48'h0;

  // Each peripheral flag is its own flip-flop that follows its event line.
  always_ff @(posedge clk_in)
  begin
    flags <= event_in;
  end

  assign flag_g1_out = flags[7:0];
  assign flag_g2_out = flags[15:8];
  assign flag_g3_out = flags[23:16];
  assign flag_g4_out = flags[31:24];
  assign flag_g5_out = flags[39:32];
  assign flag_g6_out = flags[47:40];
endmodule // pirq_src_model

// file: pirq_ctrl_bench.sv
`timescale 1ns/1ps
`include "pirq_consts.svh"

module pirq_ctrl_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] en_in = 8'hff;
  logic [7:0] prio6 = 8'hff;
  logic [47:0] ev = 48'h0;
  logic awready, wready, bvalid, arready, rvalid, hreq, lreq, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] f1, f2, f3, f4, f5, f6, m;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int g, b;

  pirq_src_model i_src (.clk_in(clk), .event_in(ev), .flag_g1_out(f1),
    .flag_g2_out(f2), .flag_g3_out(f3), .flag_g4_out(f4),
    .flag_g5_out(f5), .flag_g6_out(f6));

  pirq_ctrl i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
    .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
    .RVALID_OUT(rvalid), .RREADY_IN(rready), .FLAG_G1_IN(f1),
    .FLAG_G2_IN(f2), .FLAG_G3_IN(f3), .FLAG_G4_IN(f4), .FLAG_G5_IN(f5),
    .FLAG_G6_IN(f6), .ENABLE_G1_IN(en_in), .ENABLE_G2_IN(en_in),
    .ENABLE_G3_IN(en_in), .ENABLE_G4_IN(en_in), .PRIO_G6_IN(prio6),
    .HIGH_REQ_OUT(hreq), .LOW_REQ_OUT(lreq), .IRQ_OUT(irq));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // Implemented bits of the register at word index i.
  function automatic logic [7:0] imp(input int i);
    return (i == 0 || i == 6) ? 8'h77 : (i == 1) ? 8'hf7 : 8'hff;
  endfunction

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_lvl(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t level %b expected %b", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] v,
                     output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    axw(a, v, r);
    chk_data({30'h0, r}, {30'h0, `PIRQ_RESP_OKAY});
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (g = 0; g < 7; g++)
    begin
      axr(8'(4 * g), d, r);
      chk_data(d, (g < 2) ? 32'h0 : {24'h0, imp(g)});
      wr(8'(4 * g), 8'hff);
      axr(8'(4 * g), d, r);
      chk_data(d, {24'h0, imp(g)});
      wr(8'(4 * g), 8'h00);
      axr(8'(4 * g), d, r);
      chk_data(d, 32'h0);
    end
    $display("test register_access done");
    axw(8'h40, 8'hff, r);
    chk_data({30'h0, r}, {30'h0, `PIRQ_RESP_SLVERR});
    axr(8'h40, d, r);
    chk_data({r, d[29:0]}, {`PIRQ_RESP_SLVERR, 30'h0});
    $display("test unmapped done");
    wr(`PIRQ_OFF_EN5, 8'hff);
    ev <= 48'h40 << 32;
    settle();
    chk_lvl(hreq, 1'b0);
    wr(`PIRQ_OFF_CTRL, 8'h40);
    settle();
    chk_lvl(hreq, 1'b1);
    for (g = 0; g < 2; g++)
      for (b = 0; b < 8; b++)
        if ((imp(g) & (8'h01 << b)) != 8'h00)
        begin
          m = 8'h01 << b;
          wr(8'(4 * g), m);
          ev <= 48'(~m) << (32 + 8 * g);
          settle();
          chk_lvl(hreq, 1'b0);
          ev <= 48'(m) << (32 + 8 * g);
          settle();
          chk_lvl(hreq, 1'b1);
          chk_lvl(lreq, 1'b0);
        end
    $display("test single_level done");
    wr(`PIRQ_OFF_EN5, 8'hff);
    wr(`PIRQ_OFF_EN6, 8'hff);
    wr(`PIRQ_OFF_CTRL, 8'h80);
    for (g = 1; g < 7; g++)
      for (b = 0; b < 8; b++)
        if ((imp((g < 6) ? g + 1 : 1) & (8'h01 << b)) != 8'h00)
        begin
          m = 8'h01 << b;
          if (g < 6)
            wr(8'(4 * g + 4), m);
          else
            prio6 <= m;
          ev <= 48'(m) << (8 * g - 8);
          settle();
          chk_lvl(hreq, 1'b1);
          chk_lvl(lreq, 1'b0);
          ev <= 48'(imp((g < 6) ? g + 1 : 1) & ~m) << (8 * g - 8);
          settle();
          chk_lvl(hreq, 1'b0);
          chk_lvl(lreq, 1'b1);
        end
    $display("test two_level done");
    ev <= 48'h0;
    wr(`PIRQ_OFF_PRIO1, 8'hff);
    wr(`PIRQ_OFF_STAT, 8'h03);
    wr(`PIRQ_OFF_MASK, 8'h01);
    ev <= 48'h1;
    settle();
    chk_lvl(irq, 1'b1);
    axr(`PIRQ_OFF_STAT, d, r);
    chk_data(d, 32'h1);
    wr(`PIRQ_OFF_STAT, 8'h01);
    settle();
    chk_lvl(irq, 1'b0);
    wr(`PIRQ_OFF_MASK, 8'h00);
    ev <= 48'h0;
    settle();
    ev <= 48'h1;
    settle();
    chk_lvl(irq, 1'b0);
    axr(`PIRQ_OFF_STAT, d, r);
    chk_data(d, 32'h1);
    $display("test interrupt done");
    wr(`PIRQ_OFF_EN5, 8'h00);
    ev <= 48'h77 << 32;
    settle();
    chk_lvl(hreq, 1'b0);
    chk_lvl(lreq, 1'b0);
    $display("test group_five_masked done");
    ev <= 48'h1;
    settle();
    chk_lvl(hreq, 1'b1);
    ce <= 1'b0;
    ev <= 48'h0;
    settle();
    chk_lvl(hreq, 1'b1);
    ce <= 1'b1;
    settle();
    chk_lvl(hreq, 1'b0);
    $display("test clock_enable done");
    end_sim();
  end
endmodule // pirq_ctrl_bench
